// >>> core/ees_core.sv
/*
  Two-wire slave front end of a 16384-byte nonvolatile memory with
  a 64-byte page buffer and self-timed write cycle.
  Assumes SCL, SDA and straps arrive asynchronously and SCL is
  far slower than the core clock; SDA is open drain outside.
*/
`timescale 1ns/1ps
`default_nettype none
module ees_core
  import ees_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DEF
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic CHIP_SELECT_BIT0_I,
  input wire logic CHIP_SELECT_BIT1_I,
  input wire logic CHIP_SELECT_BIT2_I,
  input wire logic WP_I,
  output logic WRITE_BUSY_O
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  ees_core_t r;
  ees_core_t next_r;
  ees_pins_t raw;
  ees_pins_t pin;
  logic tmr_busy;
  logic busy;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic pbuf_we;
  logic mem_we;
  logic [13:0] mem_idx;
  logic [7:0] rd_byte;

  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] pbuf [PAGE_BYTES];

  // slave address match against type code and select straps
  function automatic logic addr_match(input logic [7:0] a,
                                      input logic [2:0] cs);
    addr_match = (a[7:4] == DEV_TYPE) && (a[3:1] == cs);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pins and helpers

  assign raw.scl = SCL_I;
  assign raw.sda = SDA_I;
  assign raw.wp = WP_I;
  assign raw.chip_sel = {CHIP_SELECT_BIT2_I, CHIP_SELECT_BIT1_I,
                         CHIP_SELECT_BIT0_I};

  ees_pin_sync u_sync (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .pins_i(raw),
    .pins_o(pin)
  );

  ees_wr_timer #(.CYCLES(WR_CYCLES)) u_tmr (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .start_i(r.wstart),
    .busy_o(tmr_busy)
  );

  // busy covers the gap before the timer sees its start pulse
  assign busy = tmr_busy | r.wstart | r.commit;

  // edges of the filtered bus lines
  assign scl_rise = pin.scl & ~r.scl_q;
  assign scl_fall = ~pin.scl & r.scl_q;
  assign bus_start = pin.scl & r.scl_q & r.sda_q & ~pin.sda;
  assign bus_stop = pin.scl & r.scl_q & ~r.sda_q & pin.sda;

  // byte at the live pointer, used whenever a read byte is loaded
  assign rd_byte = mem[r.addr];

  ////////////////////////////////////////////////////////////////////
  // protocol engine

  always_comb
  begin
    next_r = r;
    next_r.wstart = 1'b0;
    next_r.scl_q = pin.scl;
    next_r.sda_q = pin.sda;
    pbuf_we = 1'b0;
    mem_we = 1'b0;
    mem_idx = {r.cpage, r.cidx[5:0]};

    // commit only offsets loaded in the latest sequence
    if (r.commit)
    begin
      mem_we = r.valid[r.cidx[5:0]];
      next_r.cidx = r.cidx + 1'b1;
      if (r.cidx == PAGE_LAST)
      begin
        next_r.commit = 1'b0;
      end
    end

    // start resets the byte engine from any state
    if (bus_start)
    begin
      next_r.st = ST_DEV;
      next_r.bcnt = '0;
      next_r.ackph = 1'b0;
      next_r.oe = 1'b0;
    end
    else if (bus_stop)
    begin
      // stop after accepted data launches the write
      if (r.st == ST_WDAT && |r.valid && !r.wp_lat && !busy)
      begin
        next_r.wstart = 1'b1;
        next_r.commit = 1'b1;
        next_r.cidx = '0;
        next_r.cpage = r.addr[13:6];
      end
      next_r.st = ST_IDLE;
      next_r.oe = 1'b0;
      next_r.ackph = 1'b0;
    end
    else if (r.st != ST_IDLE)
    begin
      if (scl_rise)
      begin
        if (r.bcnt < ACK_BIT)
        begin
          // data taken on the rising clock
          next_r.sreg = {r.sreg[6:0], pin.sda};
          next_r.tx = {r.tx[6:0], 1'b1};
          next_r.bcnt = r.bcnt + 1'b1;
        end
        else
        begin
          // master acknowledge seen in ninth clock
          next_r.mack = ~pin.sda;
        end
      end
      else if (scl_fall)
      begin
        if (r.ackph)
        begin
          // end of the ninth clock: release and pick next byte
          next_r.ackph = 1'b0;
          next_r.bcnt = '0;
          next_r.oe = 1'b0;
          unique case (r.st)
            ST_DEV:
            begin
              if (r.sreg[0])
              begin
                // read starts at the live pointer
                next_r.st = ST_RDAT;
                next_r.tx = rd_byte;
                next_r.oe = ~rd_byte[7];
              end
              else
              begin
                next_r.st = ST_AHI;
              end
            end
            ST_AHI:
            begin
              next_r.st = ST_ALO;
            end
            ST_ALO:
            begin
              // protect level strobed before first data byte
              next_r.st = ST_WDAT;
              next_r.wp_lat = pin.wp;
            end
            ST_WDAT:
            begin
              next_r.st = ST_WDAT;
            end
            ST_RDAT:
            begin
              // continue on acknowledge, else drop out
              if (r.mack)
              begin
                next_r.tx = rd_byte;
                next_r.oe = ~rd_byte[7];
              end
              else
              begin
                next_r.st = ST_IDLE;
              end
            end
            ST_IDLE:
            begin
              next_r.st = ST_IDLE;
            end
          endcase
        end
        else if (r.bcnt == ACK_BIT)
        begin
          // start of the ninth clock
          next_r.ackph = 1'b1;
          unique case (r.st)
            ST_DEV:
            begin
              // match and not busy, else no ack
              if (addr_match(r.sreg, pin.chip_sel) && !busy)
              begin
                next_r.oe = 1'b1;
              end
              else
              begin
                next_r.st = ST_IDLE;
                next_r.ackph = 1'b0;
              end
            end
            ST_AHI:
            begin
              next_r.oe = 1'b1;
              next_r.ahi = r.sreg[5:0];
            end
            ST_ALO:
            begin
              next_r.oe = 1'b1;
              next_r.addr = {r.ahi, r.sreg};
              next_r.valid = '0;
            end
            ST_WDAT:
            begin
              if (r.wp_lat)
              begin
                next_r.st = ST_IDLE;
                next_r.ackph = 1'b0;
                next_r.valid = '0;
              end
              else
              begin
                next_r.oe = 1'b1;
                pbuf_we = 1'b1;
                next_r.valid[r.addr[5:0]] = 1'b1;
                next_r.addr = {r.addr[13:6], r.addr[5:0] + 6'h01};
              end
            end
            ST_RDAT:
            begin
              // release, pointer wraps over whole array
              next_r.oe = 1'b0;
              next_r.addr = r.addr + 14'h0001;
            end
            ST_IDLE:
            begin
              next_r.st = ST_IDLE;
            end
          endcase
        end
        else if (r.st == ST_RDAT)
        begin
          // next read bit set while clock is low
          next_r.oe = ~r.tx[7];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      r <= '0;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // storage

  // page buffer takes the received byte at the page offset
  always_ff @(posedge CORE_CLK_I)
  begin
    if (pbuf_we)
    begin
      pbuf[r.addr[5:0]] <= r.sreg;
    end
  end

  // array starts erased; no reset, contents are nonvolatile
  initial
  begin
    for (int i = 0; i < MEM_DEPTH; i++)
    begin
      mem[i] = MEM_ERASED;
    end
  end

  // commit one page slot per clock; plain always, the initial block also loads it
  always @(posedge CORE_CLK_I)
  begin
    if (mem_we)
    begin
      mem[mem_idx] <= pbuf[r.cidx[5:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  // open drain: level is always low, enable does the work
  assign SDA_O = 1'b0;
  // enable stays off while busy, the device address is not acknowledged then
  assign SDA_OE_O = r.oe;
  assign WRITE_BUSY_O = busy;

endmodule // ees_core
`default_nettype wire

// >>> core/ees_pin_sync.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes asynchronous pins; a change is taken once stages two
  and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module ees_pin_sync
  import ees_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire ees_pins_t pins_i,
  output ees_pins_t pins_o
);

  typedef struct packed {
    ees_pins_t s1;
    ees_pins_t s2;
    ees_pins_t s3;
    ees_pins_t q;
  } ees_sync_t;

  ees_sync_t r;
  ees_sync_t next_r;

  // first stage feeds only the second; filter looks at two and three
  always_comb
  begin
    next_r = r;
    next_r.s1 = pins_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r <= {PINS_RST, PINS_RST, PINS_RST, PINS_RST};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign pins_o = r.q;

endmodule // ees_pin_sync
`default_nettype wire

// >>> core/ees_pkg.sv
/*
  Constants, types and state layout shared by the two-wire
  nonvolatile memory slave and its helpers.
  Assumes a 250 MHz core clock and pins sampled asynchronously.
*/
// Overview of operation
// - zero is sent by pulling data low, one by releasing it
// - data changes only with clock low; changes in clock high are START/STOP
// - data falling while clock high is START; it begins every command
// - data rising while clock high is STOP; it ends every command
// - no response to anything until a START has been seen
// - respond only when type code and three select pins match address
// - address bit 0 picks direction: 1 read, 0 write
// - acknowledge in ninth clock after address, pointer and write bytes
// - read: release data in ninth clock, continue while master acknowledges
// - two pointer bytes: top 2 ignored, 8 page bits, 6 offset bits
// - data bytes fill page buffer; STOP starts the timed write
// - during the timed write keep data released, ignore requests
// - up to 64 bytes, offset wraps inside the latched page
// - only bytes of the latest write sequence are committed
// - while writing, address is not acknowledged, so masters may poll
// - protect pin sampled before first data byte; high refuses it
// - array starts with every byte erased to FFh
// - read address gets acknowledge then byte at the current pointer
// - random read: pointer write, repeated START, then read from it
// - every read byte advances the pointer, acknowledged or not; wrap at end of whole array
package ees_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 14;
  localparam int OFS_W = 6;
  localparam int AHI_W = 6;
  localparam int MEM_DEPTH = 16384;
  localparam int PAGE_BYTES = 64;
  localparam logic [7:0] MEM_ERASED = 8'hFF;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [6:0] PAGE_LAST = 7'h3F;
  // device type code, value arbitrary
  localparam logic [3:0] DEV_TYPE = 4'h5;

  // timed write: longest time, rounded down to whole cycles
  localparam int CLK_PERIOD_NS = 4;
  localparam int WR_TIME_MS = 5;
  localparam int WR_TIME_NS = WR_TIME_MS * 1000000;
  localparam int WR_CYCLES_DEF = WR_TIME_NS / CLK_PERIOD_NS;
  localparam int WR_CNT_W = 21;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic [2:0] chip_sel;
  } ees_pins_t;

  // bus idles high; straps idle low
  localparam ees_pins_t PINS_RST = 6'h30;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_AHI = 3'h3,
    ST_ALO = 3'h2,
    ST_WDAT = 3'h6,
    ST_RDAT = 3'h7
  } ees_state_t;

  typedef struct packed {
    ees_state_t st;
    logic [3:0] bcnt;
    logic ackph;
    logic [7:0] sreg;
    logic [7:0] tx;
    logic oe;
    logic [5:0] ahi;
    logic [13:0] addr;
    logic wp_lat;
    logic mack;
    logic [63:0] valid;
    logic commit;
    logic [6:0] cidx;
    logic [7:0] cpage;
    logic wstart;
    logic scl_q;
    logic sda_q;
  } ees_core_t;

endpackage

// >>> core/ees_wr_timer.sv
/*
  Self-timed write cycle counter.
  Assumes a one-cycle start pulse and CYCLES of at least 64.
*/
`timescale 1ns/1ps
`default_nettype none
module ees_wr_timer
  import ees_pkg::*;
#(
  parameter int CYCLES = WR_CYCLES_DEF
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic busy_o
);

  typedef struct packed {
    logic busy;
    logic [WR_CNT_W-1:0] cnt;
  } ees_tmr_t;

  localparam logic [WR_CNT_W-1:0] CNT_LAST = WR_CNT_W'(CYCLES - 1);

  ees_tmr_t r;
  ees_tmr_t next_r;

  // count the write time, restartable only when idle
  always_comb
  begin
    next_r = r;
    if (start_i && !r.busy)
    begin
      next_r.busy = 1'b1;
      next_r.cnt = '0;
    end
    else if (r.busy)
    begin
      next_r.cnt = r.cnt + 1'b1;
      if (r.cnt == CNT_LAST)
      begin
        next_r.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign busy_o = r.busy;

endmodule // ees_wr_timer
`default_nettype wire

// >>> verif/ees_bus_master.sv
/* Behavioural two-wire bus master, 160 ns bit time.
   Assumes calls start on a core clock falling edge. */
`timescale 1ns/1ps
`default_nettype none
module ees_bus_master
(
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // clock stands high and data released between frames
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // called only with the bus idle or as repeated start
  task automatic start();
    sda_o = 1'b1;
    #40;
    scl_o = 1'b1;
    #40;
    sda_o = 1'b0;
    #40;
    scl_o = 1'b0;
    #40;
  endtask
  // one releases, data moves only with clock low
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #40;
    scl_o = 1'b1;
    #40;
    r = sda_i;
    #40;
    scl_o = 1'b0;
    #40;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    #40;
    scl_o = 1'b1;
    #40;
    sda_o = 1'b1;
    #40;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // master acks to go on, withholds on the last byte
  task automatic rx(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(~more, r);
  endtask
endmodule // ees_bus_master
`default_nettype wire

// >>> verif/ees_core_properties.sv
/* Port checker for the two-wire memory slave.
   Assumes the pins are seen at the core clock; bound to ees_core. */
`timescale 1ns/1ps
`default_nettype none
module ees_core_properties
  import ees_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DEF
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic WP_I,
  input wire logic WRITE_BUSY_O
);
  int busy_cnt;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // busy run length; a counter avoids a huge repetition count
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      busy_cnt <= 0;
    else
      busy_cnt <= WRITE_BUSY_O ? busy_cnt + 1 : 0;
  end
  property p_drive_low; SDA_O == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("data pin driven high");
  property p_quiet_busy; WRITE_BUSY_O |-> !SDA_OE_O; endproperty
  a_quiet_busy: assert property (p_quiet_busy)
    else $error("data pulled during write cycle");
  property p_edge_low; $changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 3); endproperty
  a_edge_low: assert property (p_edge_low)
    else $error("data drive moved with clock high");
  property p_stop_starts; $rose(WRITE_BUSY_O) |-> SCL_I && SDA_I && !$past(SDA_I, 8); endproperty
  a_stop_starts: assert property (p_stop_starts)
    else $error("write cycle began without stop");
  property p_wr_time;
    $fell(WRITE_BUSY_O) |-> busy_cnt >= WR_CYCLES && busy_cnt <= WR_CYCLES + 80;
  endproperty
  a_wr_time: assert property (p_wr_time)
    else $error("write cycle length wrong");
  property p_ack_stands; $rose(SDA_OE_O) |=> SDA_OE_O [*8]; endproperty
  a_ack_stands: assert property (p_ack_stands)
    else $error("low drive too short");
  property p_wp_blocks; $rose(WRITE_BUSY_O) |-> !WP_I; endproperty
  a_wp_blocks: assert property (p_wp_blocks)
    else $error("protected write started a cycle");
  property p_start_quiet; SCL_I && $fell(SDA_I) |=> !SDA_OE_O [*8]; endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("drive right after start");
endmodule // ees_core_properties
bind ees_core ees_core_properties #(.WR_CYCLES(WR_CYCLES)) u_props (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .WP_I(WP_I), .WRITE_BUSY_O(WRITE_BUSY_O)
);
`default_nettype wire

// >>> verif/tb_top.sv
/* Self-checking bench for the two-wire memory slave.
   Assumes ees_bus_master drives the bus with a pull-up on data. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ees_pkg::*;
;
  localparam logic [7:0] dev_w = {DEV_TYPE, 3'h5, 1'b0};
  localparam logic [7:0] dev_r = {DEV_TYPE, 3'h5, 1'b1};
  logic clk;
  logic rst_n;
  logic wp;
  logic [2:0] cs;
  logic scl;
  logic sda_m;
  logic sda_oe;
  logic sda_o;
  logic busy;
  wire logic sda;
  int bad_count;
  int checks_done;
  // open-drain wire: device low wins over the master
  assign sda = sda_oe ? sda_o : sda_m;
  // write cycle long enough that a poll right after stop is refused
  ees_core #(.WR_CYCLES(1000)) DUT (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .CHIP_SELECT_BIT0_I(cs[0]),
    .CHIP_SELECT_BIT1_I(cs[1]), .CHIP_SELECT_BIT2_I(cs[2]), .WP_I(wp),
    .WRITE_BUSY_O(busy)
  );
  ees_bus_master mst (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic set_ptr(input logic [15:0] p);
    logic a;
    mst.start();
    mst.tx(dev_w, a);
    chk("addr ack", {7'h0, a}, 8'h01);
    mst.tx(p[15:8], a);
    chk("ptr hi ack", {7'h0, a}, 8'h01);
    mst.tx(p[7:0], a);
    chk("ptr lo ack", {7'h0, a}, 8'h01);
  endtask
  task automatic wr(input logic [15:0] p, input logic [31:0] d, input int n);
    logic a;
    set_ptr(p);
    for (int i = 0; i < n; i++)
    begin
      mst.tx(d[31 - 8 * i -: 8], a);
      chk("data ack", {7'h0, a}, 8'h01);
    end
  endtask
  task automatic rd3(input logic rnd, input logic [15:0] p, input logic [23:0] e);
    logic a;
    logic [7:0] d;
    if (rnd)
      set_ptr(p);
    mst.start();
    mst.tx(dev_r, a);
    chk("read ack", {7'h0, a}, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      mst.rx(i < 2, d);
      chk("read byte", d, e[23 - 8 * i -: 8]);
    end
    mst.stop();
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1200)
    begin
      @(negedge clk);
      n++;
    end
    chk("write done", {7'h0, busy}, 8'h00);
  endtask
  task automatic t_addr_match();
    logic a;
    mst.bit_io(1'b1, a);
    mst.tx(dev_w, a);
    chk("no start", {7'h0, a}, 8'h00);
    cs = 3'h6;
    mst.start();
    mst.tx(dev_w, a);
    chk("strap miss", {7'h0, a}, 8'h00);
    cs = 3'h5;
    mst.start();
    mst.tx(dev_w ^ 8'h80, a);
    chk("type miss", {7'h0, a}, 8'h00);
    mst.start();
    mst.tx(dev_w, a);
    chk("match", {7'h0, a}, 8'h01);
    mst.stop();
    $display("test addr_match done");
  endtask
  task automatic t_page_write();
    logic a;
    wr(16'h003E, 32'hA1B2C3D4, 4);
    mst.stop();
    chk("busy after stop", {7'h0, busy}, 8'h01);
    mst.start();
    mst.tx(dev_w, a);
    chk("poll busy", {7'h0, a}, 8'h00);
    mst.stop();
    wait_ready();
    mst.start();
    mst.tx(dev_w, a);
    chk("poll ready", {7'h0, a}, 8'h01);
    mst.stop();
    $display("test page_write done");
  endtask
  task automatic t_read_back();
    rd3(1'b1, 16'h003E, 24'hA1B2FF);
    rd3(1'b1, 16'h0000, 24'hC3D4FF);
    rd3(1'b1, 16'hFFFD, 24'hFFFFFF);
    rd3(1'b0, 16'h0000, 24'hC3D4FF);
    $display("test read_back done");
  endtask
  task automatic t_protect();
    logic a;
    wp = 1'b1;
    set_ptr(16'h0000);
    mst.tx(8'h55, a);
    chk("protected ack", {7'h0, a}, 8'h00);
    mst.stop();
    chk("no write cycle", {7'h0, busy}, 8'h00);
    wp = 1'b0;
    rd3(1'b1, 16'h0000, 24'hC3D4FF);
    $display("test protect done");
  endtask
  task automatic t_stale();
    wr(16'h0100, 32'h11000000, 1);
    wr(16'h0101, 32'h22000000, 1);
    mst.stop();
    wait_ready();
    rd3(1'b1, 16'h0100, 24'hFF22FF);
    $display("test stale done");
  endtask
  // watchdog: the whole run needs about 103 us
  initial
  begin
    #300000;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    bad_count = 0;
    checks_done = 0;
    rst_n = 1'b0;
    wp = 1'b0;
    cs = 3'h5;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk("oe after reset", {7'h0, sda_oe}, 8'h00);
    repeat (8) @(negedge clk);
    t_addr_match();
    t_page_write();
    t_read_back();
    t_protect();
    t_stale();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
